// [hdl/opcs_output_prot.sv]
// opcs_output_prot.sv: output switch, power-up policy, fault latches,
// current setpoint, overcurrent limit, foldback, ramp times, presets
// assumes a classic Wishbone master on sys_clk and asynchronous fault pins
`timescale 1ns/10ps
`include "opcs_consts.svh"
// Function
// - output switch command turns output on/off
// - output query reads 1 on, 0 off
// - policy OFF: power up off, switch normal
// - policy LAST: restore state, only reset disables
// - policy query reads stored OFF or LAST
// - overvoltage and overcurrent faults always latch
// - temperature and AC faults latch only policy OFF
// - clear latches when causes gone, restore output
// - current setpoint accepts zero to rated current
// - current setpoint query returns programmed value
// - limit 10-110% rated, MIN copies, MAX 110%
// - full reset sets limit to maximum
// - limit query returns programmed limit
// - foldback enable set by one or zero
// - foldback trips after 0.5 s over limit
// - foldback query reads 1 enabled, 0 disabled
// - trip query reads 1 when tripped
// - fall ramp time 0.0 to 9.9 s
// - rise ramp time 0.0 to 9.9 s
// - memory wipe erases every preset location
// - preset store writes current at index
// - preset index spans locations 0 to 15
// - full reset: current zero, limit rated+10%
module opcs_output_prot (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // retained output state from non-volatile store
   input  wire logic        savedOutOn,
   input  wire logic        savedPonLast,
   // fault and regulation pins (asynchronous)
   input  wire logic        overvoltFault,
   input  wire logic        overcurrFault,
   input  wire logic        overtempFault,
   input  wire logic        acFailFault,
   input  wire logic        constCurrMode,
   input  wire logic        currAboveLimit,
   // output stage
   output logic             outputEnable,
   output logic      [19:0] currSetMa,
   output logic      [19:0] ocLimitMa,
   output logic      [6:0]  fallRampDs,
   output logic      [6:0]  riseRampDs
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam int unsigned FOLD_CYC = `OPCS_FOLD_CYCLES; // 0.5 s in cycles

   typedef struct packed {
      logic [5:0]  syncA;        // first sync stage, pins
      logic [5:0]  syncB;        // second sync stage, pins
      logic        strapped;     // straps taken after reset
      logic        outOn;        // requested output state
      opcs_pkg::opcs_pon_t pon;  // power-up policy
      logic        foldEn;       // foldback enable
      logic        trip;         // overcurrent tripped
      logic        ovLatch;      // overvoltage latch
      logic        tempLatch;    // overtemperature latch
      logic        acLatch;      // AC-fail latch
      logic        reject;       // last argument rejected
      logic [24:0] foldCnt;      // over-limit duration
      logic [19:0] curr;         // current setpoint, mA
      logic [19:0] ocl;          // overcurrent limit, mA
      logic [6:0]  fall;         // fall ramp, 0.1 s
      logic [6:0]  rise;         // rise ramp, 0.1 s
      logic [31:0] rdData;       // read data
      logic        ack;          // bus acknowledge
   } opcs_state_t;

   opcs_state_t state;           // current state
   opcs_state_t next_state;      // next state

   opcs_mem_if memBus ();        // preset memory link

   // ----------------------------------------
   // preset memory
   // ----------------------------------------
   opcs_preset_mem u_mem (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .memPort (memBus)
   );

   // synchronised pin aliases
   logic sOv, sOc, sTemp, sAc, sCc, sAbove;
   assign {sAbove, sCc, sAc, sTemp, sOc, sOv} = state.syncB;

   // bus strobes
   logic wrStb;
   logic rdStb;
   logic faultActive;
   assign wrStb = wb_cyc_i && wb_stb_i && wb_we_i && state.ack && (&wb_sel_i); // lands at the acked edge
   assign rdStb = wb_cyc_i && wb_stb_i && !wb_we_i && !state.ack;
   assign faultActive = state.trip || state.ovLatch || state.tempLatch || state.acLatch;

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      logic [19:0] argMa;
      logic [6:0]  argDs;
      argMa = wb_dat_i[19:0];
      argDs = wb_dat_i[6:0];
      next_state = state;
      next_state.syncA = {currAboveLimit, constCurrMode, acFailFault,
                          overtempFault, overcurrFault, overvoltFault};
      next_state.syncB = state.syncA;
      next_state.ack = wb_cyc_i && wb_stb_i && !state.ack;
      memBus.req = '0;
      memBus.rdIdx = wb_adr_i[5:2];

      // straps caught once after reset release
      if (!state.strapped) begin
         next_state.strapped = 1'b1;
         next_state.pon = savedPonLast ? opcs_pkg::OPCS_PON_LAST : opcs_pkg::OPCS_PON_OFF;
         next_state.outOn = savedPonLast && savedOutOn;
      end

      // fault latching, set side
      if (sOv) begin
         next_state.ovLatch = 1'b1;
      end
      if (sOc) begin
         next_state.trip = 1'b1;
      end
      if (state.pon == opcs_pkg::OPCS_PON_OFF) begin
         if (sTemp) begin
            next_state.tempLatch = 1'b1;
         end
         if (sAc) begin
            next_state.acLatch = 1'b1;
         end
      end else begin
         next_state.tempLatch = 1'b0;
         next_state.acLatch = 1'b0;
      end

      // foldback timer: constant-current and above limit
      if (state.foldEn && sCc && sAbove) begin
         if (state.foldCnt >= 25'(FOLD_CYC - 1)) begin
            next_state.trip = 1'b1;
         end else begin
            next_state.foldCnt = state.foldCnt + 25'h0000001;
         end
      end else begin
         next_state.foldCnt = '0;
      end

      // register writes
      if (wrStb) begin
         case (wb_adr_i)
            `OPCS_ADR_CTRL: begin
               if (!(state.pon == opcs_pkg::OPCS_PON_LAST && state.outOn)) begin
                  next_state.outOn = wb_dat_i[`OPCS_CTRL_OUT];
               end
               next_state.pon = wb_dat_i[`OPCS_CTRL_PON] ? opcs_pkg::OPCS_PON_LAST
                                                         : opcs_pkg::OPCS_PON_OFF;
               next_state.foldEn = wb_dat_i[`OPCS_CTRL_FOLD];
            end
            `OPCS_ADR_CURR: begin
               if (argMa <= `OPCS_RATED_MA && wb_dat_i[31:20] == '0) begin
                  next_state.curr = argMa;
                  next_state.reject = 1'b0;
               end else begin
                  next_state.reject = 1'b1;
               end
            end
            `OPCS_ADR_OCL: begin
               if (argMa >= `OPCS_OCL_MIN_MA && argMa <= `OPCS_OCL_MAX_MA
                   && wb_dat_i[31:20] == '0) begin
                  next_state.ocl = argMa;
                  next_state.reject = 1'b0;
               end else begin
                  next_state.reject = 1'b1;
               end
            end
            `OPCS_ADR_FALL: begin
               if (argDs <= `OPCS_RAMP_MAX_DS && wb_dat_i[31:7] == '0) begin
                  next_state.fall = argDs;
                  next_state.reject = 1'b0;
               end else begin
                  next_state.reject = 1'b1;
               end
            end
            `OPCS_ADR_RISE: begin
               if (argDs <= `OPCS_RAMP_MAX_DS && wb_dat_i[31:7] == '0) begin
                  next_state.rise = argDs;
                  next_state.reject = 1'b0;
               end else begin
                  next_state.reject = 1'b1;
               end
            end
            `OPCS_ADR_PRESET: begin
               // index in bits 27:24, current in bits 19:0
               if (argMa <= `OPCS_RATED_MA && wb_dat_i[23:20] == '0
                   && wb_dat_i[31:28] == '0) begin
                  memBus.req.wr = 1'b1;
                  memBus.req.idx = wb_dat_i[27:24];
                  memBus.req.val = argMa;
                  next_state.reject = 1'b0;
               end else begin
                  next_state.reject = 1'b1;
               end
            end
            `OPCS_ADR_CMD: begin
               if (wb_dat_i[`OPCS_CMD_OCLMIN]) begin
                  next_state.ocl = state.curr;
               end
               if (wb_dat_i[`OPCS_CMD_OCLMAX]) begin
                  next_state.ocl = `OPCS_OCL_MAX_MA;
               end
               if (wb_dat_i[`OPCS_CMD_WIPE]) begin
                  memBus.req.wipe = 1'b1;
               end
               if (wb_dat_i[`OPCS_CMD_CLEAR]) begin
                  // clear each latch only when its cause is gone; set wins
                  if (!sOv) next_state.ovLatch = 1'b0;
                  if (!sOc && !(state.foldEn && sCc && sAbove)) next_state.trip = 1'b0;
                  if (!sTemp) next_state.tempLatch = 1'b0;
                  if (!sAc) next_state.acLatch = 1'b0;
               end
               if (wb_dat_i[`OPCS_CMD_RESET]) begin
                  next_state.curr = '0;
                  next_state.ocl = `OPCS_OCL_MAX_MA;
                  next_state.outOn = 1'b0;
               end
            end
            default: begin
               // read-only or unmapped: write ignored
            end
         endcase
      end

      // register reads
      if (rdStb) begin
         case (wb_adr_i)
            `OPCS_ADR_CTRL: begin
               next_state.rdData = '0;
               next_state.rdData[`OPCS_CTRL_OUT] = state.outOn;
               next_state.rdData[`OPCS_CTRL_PON] = (state.pon == opcs_pkg::OPCS_PON_LAST);
               next_state.rdData[`OPCS_CTRL_FOLD] = state.foldEn;
            end
            `OPCS_ADR_STATUS: begin
               next_state.rdData = '0;
               next_state.rdData[`OPCS_ST_OUT] = outputEnable;
               next_state.rdData[`OPCS_ST_TRIP] = state.trip;
               next_state.rdData[`OPCS_ST_OVLATCH] = state.ovLatch;
               next_state.rdData[`OPCS_ST_TEMPLATCH] = state.tempLatch;
               next_state.rdData[`OPCS_ST_ACLATCH] = state.acLatch;
               next_state.rdData[`OPCS_ST_REJECT] = state.reject;
            end
            `OPCS_ADR_CURR:   next_state.rdData = {12'h000, state.curr};
            `OPCS_ADR_OCL:    next_state.rdData = {12'h000, state.ocl};
            `OPCS_ADR_FALL:   next_state.rdData = {25'h0000000, state.fall};
            `OPCS_ADR_RISE:   next_state.rdData = {25'h0000000, state.rise};
            default: begin
               // preset and unmapped reads return zero; memory read data at rdIdx is not used
               next_state.rdData = 32'h00000000;
            end
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
         state.ocl <= `OPCS_OCL_MAX_MA;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign outputEnable = state.outOn && !faultActive;
   assign currSetMa = state.curr;
   assign ocLimitMa = state.ocl;
   assign fallRampDs = state.fall;
   assign riseRampDs = state.rise;
   assign wb_dat_o = state.rdData;
   assign wb_ack_o = state.ack;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_out_write;
      @(posedge sys_clk) disable iff (!rst_n)
      (wrStb && wb_adr_i == `OPCS_ADR_CTRL && state.strapped
       && state.pon == opcs_pkg::OPCS_PON_OFF)
      |=> state.outOn == $past(wb_dat_i[`OPCS_CTRL_OUT]);
   endproperty
   a_out_write: assert property (p_out_write) else $error("output switch ignored");

   property p_last_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      (state.strapped && state.pon == opcs_pkg::OPCS_PON_LAST && state.outOn
       && !(wrStb && wb_adr_i == `OPCS_ADR_CMD && wb_dat_i[`OPCS_CMD_RESET])) |=> state.outOn;
   endproperty
   a_last_hold: assert property (p_last_hold) else $error("policy LAST output dropped");

   property p_ov_latch;
      @(posedge sys_clk) disable iff (!rst_n)
      sOv |=> state.ovLatch && !outputEnable;
   endproperty
   a_ov_latch: assert property (p_ov_latch) else $error("overvoltage not latched");

   property p_temp_last;
      @(posedge sys_clk) disable iff (!rst_n)
      (state.pon == opcs_pkg::OPCS_PON_LAST) |=> !state.tempLatch && !state.acLatch;
   endproperty
   a_temp_last: assert property (p_temp_last) else $error("temp latched under LAST");

   property p_clear_blocked;
      @(posedge sys_clk) disable iff (!rst_n)
      sOv |=> state.ovLatch;
   endproperty
   a_clear_blocked: assert property (p_clear_blocked) else $error("latch cleared with cause");

   property p_curr_range;
      @(posedge sys_clk) disable iff (!rst_n)
      state.curr <= `OPCS_RATED_MA && state.fall <= `OPCS_RAMP_MAX_DS && state.rise <= `OPCS_RAMP_MAX_DS;
   endproperty
   a_curr_range: assert property (p_curr_range) else $error("value out of range stored");

   property p_reset_cmd;
      @(posedge sys_clk) disable iff (!rst_n)
      (wrStb && wb_adr_i == `OPCS_ADR_CMD && wb_dat_i[`OPCS_CMD_RESET])
      |=> state.curr == '0 && state.ocl == `OPCS_OCL_MAX_MA;
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("full reset values wrong");

   property p_fold_trip;
      @(posedge sys_clk) disable iff (!rst_n)
      (state.foldCnt == 25'(FOLD_CYC - 1) && state.foldEn && sCc && sAbove) |=> state.trip;
   endproperty
   a_fold_trip: assert property (p_fold_trip) else $error("foldback did not trip");

   property p_ack_once;
      @(posedge sys_clk) disable iff (!rst_n)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");
endmodule : opcs_output_prot

// [hdl/opcs_preset_mem.sv]
// opcs_preset_mem.sv: sixteen preset current locations
// assumes requests come from logic on sys_clk
`timescale 1ns/10ps
`include "opcs_consts.svh"
module opcs_preset_mem (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // request side
   opcs_mem_if.mem   memPort
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [15:0][19:0] slot;     // preset currents, mA
      logic [19:0]       rdData;   // registered read data
   } opcs_mem_state_t;

   opcs_mem_state_t state;        // current state
   opcs_mem_state_t next_state;   // next state

   // next-state logic: wipe clears all, store writes one slot
   always_comb begin
      next_state = state;
      if (memPort.req.wipe) begin
         next_state.slot = '0;
      end else if (memPort.req.wr) begin
         next_state.slot[memPort.req.idx] = memPort.req.val;
      end
      next_state.rdData = state.slot[memPort.rdIdx];
   end

   // register the state
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign memPort.rdData = state.rdData;

   // wipe empties every location on the next edge
   property p_wipe;
      @(posedge sys_clk) disable iff (!rst_n)
      memPort.req.wipe |=> (state.slot == '0);
   endproperty
   a_wipe: assert property (p_wipe) else $error("preset wipe left data");

   // store lands in its indexed slot
   property p_store;
      @(posedge sys_clk) disable iff (!rst_n)
      (memPort.req.wr && !memPort.req.wipe) |=>
         (state.slot[$past(memPort.req.idx)] == $past(memPort.req.val));
   endproperty
   a_store: assert property (p_store) else $error("preset store lost");
endmodule : opcs_preset_mem

// [pkg/opcs_consts.svh]
// opcs_consts.svh: offsets, field positions, reset values and timing counts
// assumes a 40 MHz system clock and a 32-bit classic Wishbone register bus
`ifndef OPCS_CONSTS_SVH
`define OPCS_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OPCS_ADR_CTRL      6'h00
`define OPCS_ADR_STATUS    6'h04
`define OPCS_ADR_CURR      6'h08
`define OPCS_ADR_OCL       6'h0C
`define OPCS_ADR_FALL      6'h10
`define OPCS_ADR_RISE      6'h14
`define OPCS_ADR_PRESET    6'h18
`define OPCS_ADR_CMD       6'h1C

// ----------------------------------------
// control register fields
// ----------------------------------------
`define OPCS_CTRL_OUT      0
`define OPCS_CTRL_PON      1
`define OPCS_CTRL_FOLD     2

// ----------------------------------------
// command register bits (write one to act)
// ----------------------------------------
`define OPCS_CMD_RESET     0
`define OPCS_CMD_CLEAR     1
`define OPCS_CMD_WIPE      2
`define OPCS_CMD_OCLMIN    3
`define OPCS_CMD_OCLMAX    4

// ----------------------------------------
// status register fields
// ----------------------------------------
`define OPCS_ST_OUT        0
`define OPCS_ST_TRIP       1
`define OPCS_ST_OVLATCH    2
`define OPCS_ST_TEMPLATCH  3
`define OPCS_ST_ACLATCH    4
`define OPCS_ST_REJECT     5

// ----------------------------------------
// value scaling: currents in mA, ramp times in tenths of a second, foldback time in ms
// ----------------------------------------
`define OPCS_RATED_MA      20'h186A0
`define OPCS_OCL_MIN_MA    20'h02710
`define OPCS_OCL_MAX_MA    20'h1ADB0
`define OPCS_RAMP_MAX_DS   7'h63
`define OPCS_FOLD_TIME_MS  500
`define OPCS_CLK_HZ        40000000
`define OPCS_FOLD_CYCLES   (`OPCS_FOLD_TIME_MS * (`OPCS_CLK_HZ / 1000))

`endif

// [pkg/opcs_mem_if.sv]
// opcs_mem_if.sv: carries preset store requests and read data
// assumes one sys_clk domain shared by both ends
`timescale 1ns/10ps
interface opcs_mem_if;
   opcs_pkg::opcs_memreq_t req;     // store or wipe request
   logic [3:0]             rdIdx;   // read location
   logic [19:0]            rdData;  // stored current at rdIdx
   modport ctrl (output req, output rdIdx, input rdData);
   modport mem  (input req, input rdIdx, output rdData);
endinterface : opcs_mem_if

// [pkg/opcs_pkg.sv]
// opcs_pkg.sv: types of the output protection command set
// assumes opcs_consts.svh for all numeric values
package opcs_pkg;
   // power-up output policy
   typedef enum logic {OPCS_PON_OFF, OPCS_PON_LAST} opcs_pon_t;
   // preset memory request
   typedef struct packed {
      logic       wr;
      logic       wipe;
      logic [3:0] idx;
      logic [19:0] val;
   } opcs_memreq_t;
endpackage : opcs_pkg

// [verif/opcs_host_model.sv]
// opcs_host_model.sv: remote controller model issuing classic wishbone cycles
// assumes the design acks every request on sys_clk
`timescale 1ns/10ps
module opcs_host_model (
   // clock
   input  wire logic        sys_clk,
   // request side
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [5:0]       adr,
   output logic [3:0]       sel,
   output logic [31:0]      datOut,
   // answer side
   input  wire logic        ack,
   input  wire logic [31:0] datIn
);
   // ----------------------------------------
   // bus cycle
   // ----------------------------------------
   // idle bus at time zero
   initial begin
      {cyc, stb, we, adr, sel, datOut} = '0;
   end

   // one cycle, request held until ack is sampled high
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      {cyc, stb, we, adr, sel, datOut} <= {2'b11, w, a, 4'hF, d};
      do @(posedge sys_clk); while (ack !== 1'b1);
      q = datIn;
      {cyc, stb} <= 2'b00;
   endtask : xfer
endmodule : opcs_host_model

// [verif/testbench.sv]
// testbench.sv: self-checking bench for the output protection block
// assumes opcs_consts.svh on the include path and the host model beside it
`timescale 1ns/10ps
`include "opcs_consts.svh"
module testbench;
   logic        sys_clk;
   logic        rst_n;
   logic        cyc, stb, we, ack;
   logic [5:0]  adr;
   logic [3:0]  sel;
   logic [31:0] datW, datR;
   logic        savedOutOn, savedPonLast, ovF, ocF, otF, acF, ccMode, above;
   logic        outEn;
   logic [19:0] currSet, ocLim;
   logic [6:0]  fallDs, riseDs;
   int          errTotal = 0;
   int          checksDone = 0;

   opcs_host_model host (.sys_clk(sys_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
      .datOut(datW), .ack(ack), .datIn(datR));
   opcs_output_prot dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
      .savedOutOn(savedOutOn), .savedPonLast(savedPonLast), .overvoltFault(ovF), .overcurrFault(ocF),
      .overtempFault(otF), .acFailFault(acF), .constCurrMode(ccMode), .currAboveLimit(above),
      .outputEnable(outEn), .currSetMa(currSet), .ocLimitMa(ocLim), .fallRampDs(fallDs), .riseRampDs(riseDs));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // write, then let the edge's updates land
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      host.xfer(1'b1, a, d, q);
      @(negedge sys_clk);
   endtask : wr
   // value compare
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checksDone++;
      if (g !== e) begin
         errTotal++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // read one field of a register and compare
   task automatic chkRd(input string nm, input logic [5:0] a, input int b, input int w, input logic [31:0] e);
      logic [31:0] q;
      host.xfer(1'b0, a, 32'h0, q);
      chk(nm, e, (q >> b) & ((64'h1 << w) - 1));
   endtask : chkRd
   // drive fault pins, allow for the two-flop synchroniser
   task automatic pins(input logic [3:0] f);
      @(posedge sys_clk);
      {ovF, ocF, otF, acF} <= f;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : pins

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // setpoint and limit ranges, min/max, full reset
   task automatic t_values();
      chk("ocl_rst", 32'h0001ADB0, {12'h0, ocLim});
      wr(`OPCS_ADR_CMD, 32'h00000001);
      wr(`OPCS_ADR_CURR, 32'h000186A0);
      chkRd("curr", `OPCS_ADR_CURR, 0, 20, 32'h000186A0);
      wr(`OPCS_ADR_CURR, 32'h000186A1);
      chk("curr_bad", 32'h000186A0, {12'h0, currSet});
      chkRd("reject", `OPCS_ADR_STATUS, `OPCS_ST_REJECT, 1, 1);
      wr(`OPCS_ADR_OCL, 32'h0000270F);
      chkRd("ocl_low", `OPCS_ADR_OCL, 0, 20, 32'h0001ADB0);
      wr(`OPCS_ADR_OCL, 32'h00002710);
      chk("ocl_10", 32'h00002710, {12'h0, ocLim});
      wr(`OPCS_ADR_OCL, 32'h0001ADB1);
      chk("ocl_high", 32'h00002710, {12'h0, ocLim});
      wr(`OPCS_ADR_CMD, 32'h00000010);
      chk("ocl_max", 32'h0001ADB0, {12'h0, ocLim});
      wr(`OPCS_ADR_CMD, 32'h00000008);
      chk("ocl_min", 32'h000186A0, {12'h0, ocLim});
      wr(`OPCS_ADR_CMD, 32'h00000001);
      chk("rst_curr", 32'h0, {12'h0, currSet});
      chk("rst_ocl", 32'h0001ADB0, {12'h0, ocLim});
   endtask : t_values

   // switch, foldback flag, ramps, presets, unmapped place
   task automatic t_ctrl();
      wr(`OPCS_ADR_CTRL, 32'h00000001);
      chkRd("out_on", `OPCS_ADR_STATUS, `OPCS_ST_OUT, 1, 1);
      chk("out_pin", 1, outEn);
      wr(`OPCS_ADR_CTRL, 32'h00000004);
      chkRd("fold_on", `OPCS_ADR_CTRL, `OPCS_CTRL_FOLD, 1, 1);
      chkRd("out_off", `OPCS_ADR_STATUS, `OPCS_ST_OUT, 1, 0);
      wr(`OPCS_ADR_CTRL, 32'h00000000);
      chkRd("fold_off", `OPCS_ADR_CTRL, `OPCS_CTRL_FOLD, 1, 0);
      wr(`OPCS_ADR_FALL, 32'h00000063);
      wr(`OPCS_ADR_FALL, 32'h00000064);
      chkRd("fall", `OPCS_ADR_FALL, 0, 7, 32'h63);
      chk("fall_pin", 32'h63, {25'h0, fallDs});
      wr(`OPCS_ADR_RISE, 32'h0000001E);
      chk("rise_30", 32'h1E, {25'h0, riseDs});
      wr(`OPCS_ADR_RISE, 32'h00000000);
      chk("rise", 32'h0, {25'h0, riseDs});
      wr(`OPCS_ADR_PRESET, 32'h0F0186A0);
      wr(`OPCS_ADR_CMD, 32'h00000004);
      chkRd("preset", `OPCS_ADR_PRESET, 0, 32, 32'h0);
      wr(6'h20, 32'hFFFFFFFF);
      chkRd("unmapped", 6'h20, 0, 32, 32'h0);
   endtask : t_ctrl

   // latch, clear while present, clear after, per fault pin
   task automatic t_faults();
      int st [4] = '{`OPCS_ST_OVLATCH, `OPCS_ST_TRIP, `OPCS_ST_TEMPLATCH, `OPCS_ST_ACLATCH};
      for (int i = 0; i < 4; i++) begin
         wr(`OPCS_ADR_CTRL, 32'h00000001);
         pins(4'h8 >> i);
         wr(`OPCS_ADR_CMD, 32'h00000002);
         pins(4'h0);
         chk("held", 0, outEn);
         chkRd("latch", `OPCS_ADR_STATUS, st[i], 1, 1);
         wr(`OPCS_ADR_CMD, 32'h00000002);
         chk("restored", 1, outEn);
         chkRd("unlatched", `OPCS_ADR_STATUS, st[i], 1, 0);
      end
      wr(`OPCS_ADR_CTRL, 32'h00000003);
      for (int i = 2; i < 4; i++) begin
         pins(4'h8 >> i);
         pins(4'h0);
         chk("no_latch", 1, outEn);
      end
      wr(`OPCS_ADR_CTRL, 32'h00000002);
      chk("last_on", 1, outEn);
      @(posedge sys_clk);
      {ccMode, above} <= 2'b11;
      repeat (100) @(posedge sys_clk);
      chkRd("no_fold", `OPCS_ADR_STATUS, `OPCS_ST_TRIP, 1, 0);
      {ccMode, above} <= 2'b00;
      wr(`OPCS_ADR_CMD, 32'h00000001);
      chk("rst_off", 0, outEn);
   endtask : t_faults

   // reset with retained straps
   task automatic pwr(input logic pl, input logic on, input logic e);
      @(posedge sys_clk);
      {savedPonLast, savedOutOn, rst_n} <= {pl, on, 1'b0};
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("pwr_out", e, outEn);
      chkRd("policy", `OPCS_ADR_CTRL, `OPCS_CTRL_PON, 1, pl);
   endtask : pwr

   // ----------------------------------------
   // clock, run, verdict
   // ----------------------------------------
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", errTotal, checksDone);
      if (errTotal == 0 && checksDone > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // watchdog well beyond the few hundred cycles of the run
   initial begin
      repeat (50000) @(posedge sys_clk);
      errTotal++;
      close_out();
   end

   initial begin
      rst_n = 1'b0;
      {savedOutOn, savedPonLast, ovF, ocF, otF, acF, ccMode, above} = '0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      t_values();
      t_ctrl();
      t_faults();
      pwr(1'b0, 1'b1, 1'b0);
      pwr(1'b1, 1'b1, 1'b1);
      pwr(1'b1, 1'b0, 1'b0);
      close_out();
   end
endmodule : testbench
